// ===== rtl/pmc_power_mode_control.sv
// Power mode control: mode pin decode, register reload and transition-done flag
module pmc_power_mode_control
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Variant strap: high for the fuller four-mode variant
  input wire logic full_variant_i,
  // Mode pins from the host
  input wire logic mode_select_high_pin_i,
  input wire logic mode_select_low_pin_i,
  // Host register writes
  input wire pmc_host_s host_i,
  // Control register writes from the rest of the device
  input wire logic ctrl_wr_i,
  input wire logic [31:0] ctrl_wdata_i,
  input wire logic lpthr_wr_i,
  input wire logic [7:0] lpthr_wdata_i,
  input wire logic cfg2_wr_i,
  input wire logic [15:0] cfg2_wdata_i,
  // Other interrupt sources for the first line
  input wire logic first_irq_event_i,
  // Register images
  output logic [31:0] ctrl_o,
  output logic [7:0] low_power_threshold_register_o,
  output logic [15:0] second_configuration_register_o,
  output logic [15:0] first_status_register_o,
  output logic [15:0] mask_o,
  // Mode and interrupt lines
  output logic [1:0] mode_o,
  output logic transitioning_o,
  output logic first_interrupt_line_n_o,
  output logic second_interrupt_line_n_o
);

  // Transition sequencer states
  // Idle, one reload cycle, then a timed wait before the flag is raised
  typedef enum logic [1:0] {
    ST_RUN,
    ST_RELOAD,
    ST_WAIT
  } pmc_state_e;

  // Synchronised pins and decoded mode
  // The mode register holds the last decode; the live decode is compared with it
  logic [1:0] pins_sync;
  pmc_mode_e mode_now;
  pmc_mode_e mode_reg;
  pmc_state_e state_reg;
  pmc_state_e state_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic enter_normal;
  logic trans_start;  // One-cycle strobe as the sequencer leaves idle
  logic trans_end;

  // Register images and flags
  // Image registers stand in for the wider register file of the device
  logic [31:0] ctrl_reg;
  logic [7:0] lpthr_reg;
  logic [15:0] cfg2_reg;
  logic [15:0] mask_reg;
  logic done_reg;
  logic done_next;
  logic first_irq_reg;
  logic first_irq_next;
  logic first_line_n_reg;
  logic second_line_n_reg;
  logic trans_reg;
  logic done_clr;

  // Pins pass three synchroniser stages and the filter register before decode
  // Raw pins are asynchronous to clk_i; only the filtered level is decoded
  pmc_pin_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i({mode_select_high_pin_i, mode_select_low_pin_i}),
    .level_o(pins_sync)
  );

  // Decode the settled pins; variant restricts the set
  // Codes the two-mode variant lacks fall back to sleep, the pull-up state
  assign mode_now = pmc_decode(pins_sync, full_variant_i);

  // A change from any other mode into normal starts a transition
  // Leaving and re-entering normal during the wait does not restart it,
  // because the request is only acted on in the idle state
  assign enter_normal = (mode_now == PMC_NORMAL) && (mode_reg != PMC_NORMAL);
  assign trans_start = (state_reg == ST_RUN) && enter_normal;
  // The wait ends on the cycle the count reaches one
  assign trans_end = (state_reg == ST_WAIT) && (cnt_reg == 8'h01);

  // Sequencer: reload one cycle, then wait out the transition time
  // The reload state lasts one cycle so a write in flight cannot split it
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (enter_normal) begin
          state_next = ST_RELOAD;
        end
      end
      ST_RELOAD: begin
        // Load the wait length, counted in master clock cycles
        state_next = ST_WAIT;
        cnt_next = PMC_CNT_W'(PMC_TRANS_CYC);
      end
      ST_WAIT: begin
        // Count down; the end strobe and the return to idle share a cycle
        cnt_next = cnt_reg - 8'h01;
        if (trans_end) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        // Unused state code; fall back to idle
        state_next = ST_RUN;
      end
    endcase
  end

  // Host clear of the done bit by writing one
  // Only bit 15 of the written word acts; other written bits are ignored
  assign done_clr = host_i.status_wr && host_i.status_wdata[PMC_DONE_BIT];

  // Set wins over clear; no mask term gates this path
  // A new transition forces the flag low so that it reads zero while busy
  assign done_next = trans_end ? 1'b1 :
                     ((done_clr || trans_start) ? 1'b0 : done_reg);

  // First line sticky source, cleared by any status write
  // The first line has no transition duty; it only mirrors this sticky source
  assign first_irq_next = first_irq_event_i ? 1'b1 :
                          (host_i.status_wr ? 1'b0 : first_irq_reg);

  // Sequencer state and mode
  // The busy output comes from the next state so it rises with the reload state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_RUN;
      cnt_reg <= 8'h00;
      mode_reg <= PMC_SLEEP;
      trans_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      mode_reg <= mode_now;
      trans_reg <= (state_next != ST_RUN);
    end
  end

  // Register images; reload keeps threshold and second configuration
  // Control and mask writes arriving during the reload cycle lose to the defaults
  // Trade-off: writes during the wait land, so software may preset early
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= PMC_CTRL_RST;
      mask_reg <= PMC_STATUS_RST;
      lpthr_reg <= PMC_LPTHR_RST;
      cfg2_reg <= PMC_CFG2_RST;
    end else begin
      if (state_reg == ST_RELOAD) begin
        ctrl_reg <= PMC_CTRL_RST;
        mask_reg <= PMC_STATUS_RST;
      end else begin
        if (ctrl_wr_i) begin
          ctrl_reg <= ctrl_wdata_i;
        end
        if (host_i.mask_wr) begin
          mask_reg <= host_i.mask_wdata;
        end
      end
      // Threshold and second configuration never reload here
      // They carry low-power settings across modes, so a return keeps them
      if (lpthr_wr_i) begin
        lpthr_reg <= lpthr_wdata_i;
      end
      if (cfg2_wr_i) begin
        cfg2_reg <= cfg2_wdata_i;
      end
    end
  end

  // Flags and active-low lines, all registered
  // Lines come from next-state values so they move on the same edge as flags
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_reg <= 1'b0;
      first_irq_reg <= 1'b0;
      first_line_n_reg <= 1'b1;
      second_line_n_reg <= 1'b1;
    end else begin
      done_reg <= done_next;
      first_irq_reg <= first_irq_next;
      first_line_n_reg <= ~first_irq_next;
      second_line_n_reg <= ~done_next;
    end
  end

  // Outputs straight from flip-flops
  // Unused status bits are tied low; only the done flag lives here
  assign ctrl_o = ctrl_reg;
  assign low_power_threshold_register_o = lpthr_reg;
  assign second_configuration_register_o = cfg2_reg;
  assign first_status_register_o = {done_reg, 15'h0000};
  assign mask_o = mask_reg;
  assign mode_o = mode_reg;
  assign transitioning_o = trans_reg;
  assign first_interrupt_line_n_o = first_line_n_reg;
  assign second_interrupt_line_n_o = second_line_n_reg;

endmodule : pmc_power_mode_control

// ===== rtl/pmc_pkg.sv
// Package for the power mode control block: mode codes, widths, timing counts
package pmc_pkg;

  // Mode pin codes, high pin then low pin
  localparam logic [1:0] PMC_CODE_NORMAL = 2'h1;
  localparam logic [1:0] PMC_CODE_REDUCED = 2'h0;
  localparam logic [1:0] PMC_CODE_LOW = 2'h2;
  localparam logic [1:0] PMC_CODE_SLEEP = 2'h3;

  // Status register layout
  localparam int PMC_DONE_BIT = 15;
  localparam int PMC_REG_W = 16;
  localparam logic [15:0] PMC_STATUS_RST = 16'h0000;

  // Register image defaults (control reloaded on return to normal mode; threshold and second configuration only at reset)
  localparam int PMC_CTRL_W = 32;
  localparam logic [31:0] PMC_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] PMC_LPTHR_RST = 8'h07;
  localparam logic [15:0] PMC_CFG2_RST = 16'h0000;

  // Transition time in nanoseconds and its cycle count at 100 MHz
  localparam int PMC_CLK_NS = 10;
  localparam int PMC_TRANS_NS = 200;
  localparam int PMC_TRANS_CYC = (PMC_TRANS_NS + PMC_CLK_NS - 1) / PMC_CLK_NS;
  localparam int PMC_CNT_W = 8;

  // Operating modes
  typedef enum logic [1:0] {
    PMC_NORMAL,
    PMC_REDUCED,
    PMC_LOW,
    PMC_SLEEP
  } pmc_mode_e;

  // Host access to the status and mask registers
  typedef struct packed {
    logic status_wr;
    logic [15:0] status_wdata;
    logic mask_wr;
    logic [15:0] mask_wdata;
  } pmc_host_s;

  // Mode pin decode; the reduced variant only knows normal and sleep
  function automatic pmc_mode_e pmc_decode(input logic [1:0] code, input logic full);
    pmc_mode_e m;
    m = PMC_SLEEP;
    if (code == PMC_CODE_NORMAL) begin
      m = PMC_NORMAL;
    end else if (code == PMC_CODE_SLEEP) begin
      m = PMC_SLEEP;
    end else if (full && code == PMC_CODE_REDUCED) begin
      m = PMC_REDUCED;
    end else if (full && code == PMC_CODE_LOW) begin
      m = PMC_LOW;
    end
    return m;
  endfunction : pmc_decode

endpackage : pmc_pkg

// ===== rtl/pmc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter for the mode pins
module pmc_pin_sync
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Raw pin levels and the settled result
  input wire logic [1:0] pin_i,
  output logic [1:0] level_o
);

  // Stage registers; stage one feeds only stage two
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic [1:0] level_reg;
  logic [1:0] level_next;

  // Each bit updates only when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bit
      assign level_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : level_reg[g];
    end
  endgenerate

  // Pins pull up internally, so reset to all ones (sleep)
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_reg <= PMC_CODE_SLEEP;
      s2_reg <= PMC_CODE_SLEEP;
      s3_reg <= PMC_CODE_SLEEP;
      level_reg <= PMC_CODE_SLEEP;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;

endmodule : pmc_pin_sync

// ===== testbench/pmc_host_model.sv
// Host-side model that drives the two mode pins
module pmc_host_model (
  // Requested code and drive enable
  input wire logic [1:0] code_i,
  input wire logic drive_i,
  // Mode pins toward the device
  output logic [1:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins fall to the pull-up level, which reads as sleep
  assign pins_o = drive_i ? code_i : 2'h3;
endmodule : pmc_host_model

// ===== testbench/pmc_power_mode_control_assertions.sv
// Port checker for the power mode control block
module pmc_power_mode_control_assertions
  import pmc_pkg::*;
(
  // Clock, reset, strap and pins
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic full_variant_i,
  input wire logic mode_select_high_pin_i,
  input wire logic mode_select_low_pin_i,
  input wire pmc_host_s host_i,
  // Watched outputs
  input wire logic [31:0] ctrl_o,
  input wire logic [7:0] low_power_threshold_register_o,
  input wire logic [15:0] second_configuration_register_o,
  input wire logic [15:0] first_status_register_o,
  input wire logic [15:0] mask_o,
  input wire logic [1:0] mode_o,
  input wire logic transitioning_o,
  input wire logic second_interrupt_line_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Expected mode; the two-mode variant reads unknown codes as sleep
  wire logic [1:0] pins_w = {mode_select_high_pin_i, mode_select_low_pin_i};
  wire logic [1:0] exp_w = (pins_w == 2'h1) ? 2'h0 : !full_variant_i ? 2'h3 :
                           (pins_w == 2'h0) ? 2'h1 : pins_w;
  wire logic done_w = first_status_register_o[PMC_DONE_BIT];
  wire logic clr_w = host_i.status_wr && host_i.status_wdata[15] && !transitioning_o;
  // Pins and strap quiet, then the transition hold and its bounded end
  sequence s_quiet; $stable({pins_w, full_variant_i}); endsequence
  sequence s_hold; transitioning_o throughout (1'b1 ##18 1'b1); endsequence
  sequence s_end; ##[1:4] $fell(transitioning_o); endsequence
  a_mode_decode: assert property (s_quiet [*6] |-> mode_o == exp_w)
    else $error("mode output disagrees with settled pins");
  a_trans_len: assert property ($rose(transitioning_o) |-> s_hold ##0 s_end)
    else $error("transition length wrong");
  a_reload_defaults: assert property ($rose(transitioning_o) |=>
    ctrl_o == PMC_CTRL_RST && mask_o == 16'h0000)
    else $error("control image not reloaded");
  a_keep_regs: assert property ($rose(transitioning_o) |=>
    $stable(low_power_threshold_register_o) && $stable(second_configuration_register_o))
    else $error("kept register changed on reload");
  a_done_at_end: assert property ($fell(transitioning_o) |-> done_w)
    else $error("done flag missing at transition end");
  a_flag_line_tie: assert property (done_w != second_interrupt_line_n_o)
    else $error("second line does not follow done flag");
  a_busy_flag_low: assert property (transitioning_o |-> !done_w)
    else $error("done flag set during transition");
  a_host_clear: assert property (clr_w |=> !done_w && second_interrupt_line_n_o)
    else $error("done flag not cleared by host write");
endmodule : pmc_power_mode_control_assertions
bind pmc_power_mode_control pmc_power_mode_control_assertions u_chk (.*);

// ===== testbench/tb_top.sv
// Self-checking bench for the power mode control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pmc_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic full_variant_i = 1'b1;
  logic [1:0] code = 2'h3;
  logic drive = 1'b0;
  logic [1:0] pins;
  pmc_host_s host_i = '0;
  logic ctrl_wr_i = 1'b0;
  logic [31:0] ctrl_wdata_i = '0;
  logic lpthr_wr_i = 1'b0;
  logic [7:0] lpthr_wdata_i = '0;
  logic cfg2_wr_i = 1'b0;
  logic [15:0] cfg2_wdata_i = '0;
  logic first_irq_event_i = 1'b0;
  logic [31:0] ctrl_o;
  logic [7:0] lpthr_o;
  logic [15:0] cfg2_o, status_o, mask_o;
  logic [1:0] mode_o;
  logic transitioning_o, line1_n, line2_n;
  // Reference model state
  logic [31:0] m_ctrl = '0, r;
  logic [7:0] m_lp = 8'h07;
  logic [15:0] m_cfg = '0, m_mask = '0;
  logic [1:0] m_mode = 2'h3;
  logic m_flag = 1'b0;
  logic [31:0] seed = 32'h0000_caf4;
  logic [2:0] tbl [5] = '{3'h4, 3'h6, 3'h7, 3'h0, 3'h2};
  int n_fail = 0, samples_checked = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  pmc_host_model u_pmc_host_model (.code_i(code), .drive_i(drive), .pins_o(pins));
  pmc_power_mode_control u_pmc_power_mode_control (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .full_variant_i(full_variant_i), .mode_select_high_pin_i(pins[1]),
    .mode_select_low_pin_i(pins[0]), .host_i(host_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_wdata_i(ctrl_wdata_i), .lpthr_wr_i(lpthr_wr_i), .lpthr_wdata_i(lpthr_wdata_i),
    .cfg2_wr_i(cfg2_wr_i), .cfg2_wdata_i(cfg2_wdata_i), .first_irq_event_i(first_irq_event_i),
    .ctrl_o(ctrl_o), .low_power_threshold_register_o(lpthr_o),
    .second_configuration_register_o(cfg2_o), .first_status_register_o(status_o),
    .mask_o(mask_o), .mode_o(mode_o), .transitioning_o(transitioning_o),
    .first_interrupt_line_n_o(line1_n), .second_interrupt_line_n_o(line2_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Compare every image against the model
  task automatic check_all;
    chk("ctrl", m_ctrl, ctrl_o);
    chk("lpthr", m_lp, lpthr_o);
    chk("cfg2", m_cfg, cfg2_o);
    chk("mask", m_mask, mask_o);
    chk("status", {m_flag, 15'h0000}, status_o);
    chk("line2", !m_flag, line2_n);
    chk("mode", m_mode, mode_o);
  endtask : check_all
  // Enter normal mode; the wait is bounded, and the mask is set in mid-wait
  task automatic go_normal;
    int k = 0;
    code = PMC_CODE_NORMAL;
    drive = 1'b1;
    while (transitioning_o !== 1'b1 && k < 20) begin
      step(1);
      k++;
    end
    step(10);
    chk("busy", 1'b0, status_o[PMC_DONE_BIT]);
    chk("transitioning", 1'b1, transitioning_o);
    chk("mask reload", 16'h0000, mask_o);
    // All mask bits set, bit 15 included, must not hold back the done line
    host_i.mask_wr = 1'b1;
    host_i.mask_wdata = 16'hffff;
    step(1);
    host_i.mask_wr = 1'b0;
    while (transitioning_o !== 1'b0 && k < 60) begin
      step(1);
      k++;
    end
    m_ctrl = '0;
    m_mask = 16'hffff;
    m_mode = 2'h0;
    m_flag = 1'b1;
    check_all();
  endtask : go_normal
  // Pulse a status write, check the answer, then let one edge pass
  task automatic host_clear(input logic b);
    host_i.status_wr = 1'b1;
    host_i.status_wdata = {b, 15'h0000};
    step(1);
    host_i.status_wr = 1'b0;
    m_flag = m_flag & !b;
    check_all();
    chk("line1", 1'b1, line1_n);
    step(1);
  endtask : host_clear
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    step(20);
    sys_rst_i = 1'b0;
    step(8);
    check_all();
    chk("line1", 1'b1, line1_n);
    go_normal();
    // Leave normal with the flag still set; the next entry must drop it while busy
    code = PMC_CODE_SLEEP;
    step(8);
    m_mode = 2'h3;
    check_all();
    go_normal();
    host_clear(1'b1);
    $display("test start done");
    foreach (tbl[i]) begin
      r = rnd();
      {ctrl_wr_i, lpthr_wr_i, cfg2_wr_i, host_i.mask_wr} = 4'hf;
      ctrl_wdata_i = r;
      lpthr_wdata_i = r[7:0];
      cfg2_wdata_i = r[23:8];
      host_i.mask_wdata = r[31:16] | 16'h8000;
      step(1);
      {ctrl_wr_i, lpthr_wr_i, cfg2_wr_i, host_i.mask_wr} = 4'h0;
      {m_ctrl, m_lp, m_cfg, m_mask} = {r, r[7:0], r[23:8], host_i.mask_wdata};
      first_irq_event_i = 1'b1;
      {full_variant_i, code} = tbl[i];
      step(1);
      first_irq_event_i = 1'b0;
      chk("line1", 1'b0, line1_n);
      step(8);
      m_mode = !full_variant_i ? 2'h3 : (code == 2'h0) ? 2'h1 : code;
      check_all();
      go_normal();
      host_clear(1'b0);
      host_clear(1'b1);
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule : tb_top
